//--- rtl/ccb_cfg_regs.sv
`timescale 1ns/1ps
// Configuration bytes 5 to 13 behind the serial management engine
module ccb_cfg_regs
  import ccb_pkg::*;
#(
  parameter logic [1:0] VARIANT = VARIANT_100,
  parameter logic [1:0] FACTORY_FB_ZOUT = ZOUT_100,
  parameter logic [1:0] FACTORY_OUT0_ZOUT = ZOUT_100,
  parameter logic [1:0] FACTORY_OUT1_ZOUT = ZOUT_100
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Byte write from the protocol engine
  input wire ccb_wr_type wr_i,
  // Byte read from the protocol engine
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Block read length for the protocol engine
  output logic [4:0] readback_length_o,
  // Power down
  input wire logic pd_i,
  output logic keep_config_in_powerdown_o,
  // Output enables
  input wire logic [1:0] out_en_bit_i,
  input wire logic [1:0] out_pin_en_i,
  output logic [1:0] stopped_output_state_o,
  // Differential output drive requests
  output ccb_drive_type out0_drive_o,
  output ccb_drive_type out1_drive_o,
  // Impedance selects
  output logic [1:0] feedback_impedance_sel_o,
  output logic [1:0] out0_impedance_sel_o,
  output logic [1:0] out1_impedance_sel_o,
  // Impedance in ohms, zero for the reserved code
  output logic [6:0] feedback_ohms_o,
  output logic [6:0] out0_ohms_o,
  output logic [6:0] out1_ohms_o,
  output logic [2:0] zout_reserved_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Defaults

  // Factory parameters only matter on the programmable variant
  localparam logic [1:0] FB_Z_RST = ccb_zout_default(VARIANT,
    FACTORY_FB_ZOUT);
  localparam logic [1:0] OUT0_Z_RST = ccb_zout_default(VARIANT,
    FACTORY_OUT0_ZOUT);
  localparam logic [1:0] OUT1_Z_RST = ccb_zout_default(VARIANT,
    FACTORY_OUT1_ZOUT);

  // Writable fields
  logic [1:0] part_class_code;
  logic [5:0] part_number_code;
  logic [4:0] readback_length;
  logic keep_config_in_powerdown;
  logic [1:0] stopped_output_state;
  logic [1:0] feedback_impedance_sel;
  logic [1:0] out0_impedance_sel;
  logic [1:0] out1_impedance_sel;

  // Power-down tracking
  ccb_pd_state_type pd_state;
  ccb_pd_state_type next_pd_state;
  logic restore;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Address match shared by every writable byte, kept in one place
  // so the write decodes cannot drift apart
  function automatic logic wr_hit(input ccb_wr_type w, input logic [7:0] a);
    return w.en && (w.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power-down sequencing

  // Enter on pd_i, leave when it drops
  always_comb begin
    next_pd_state = pd_state;
    unique case (pd_state)
      CCB_ACTIVE: begin
        if (pd_i) begin
          next_pd_state = CCB_POWERED_DOWN;
        end
      end
      CCB_POWERED_DOWN: begin
        if (!pd_i) begin
          next_pd_state = CCB_ACTIVE;
        end
      end
    endcase
  end

  // State register of the power-down tracker
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_state <= CCB_ACTIVE;
    end else begin
      pd_state <= next_pd_state;
    end
  end

  // Held while down with keep cleared so a write cannot sneak in
  assign restore = (pd_state == CCB_POWERED_DOWN) &&
    !keep_config_in_powerdown;

  ////////////////////////////////////////////////////////////////////////////
  // Identity byte 6

  // Writable identity; a restore puts the coded values back
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      part_class_code <= PART_CLASS_RST;
      part_number_code <= PART_NUMBER_RST;
    end else if (restore) begin
      part_class_code <= PART_CLASS_RST;
      part_number_code <= PART_NUMBER_RST;
    end else if (wr_hit(wr_i, ADDR_PART_CODE)) begin
      part_class_code <= wr_i.data[CLASS_LSB +: 2];
      part_number_code <= wr_i.data[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block read length, byte 7

  // Upper three bits are reserved and dropped
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      readback_length <= BLOCK_LEN_RST;
    end else if (restore) begin
      readback_length <= BLOCK_LEN_RST;
    end else if (wr_hit(wr_i, ADDR_BLOCK_LEN)) begin
      readback_length <= wr_i.data[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down keep, byte 10

  // Not itself cleared by a restore: clearing it could never be undone
  // Refused while down so the restore decision cannot change midway
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      keep_config_in_powerdown <= KEEP_RST;
    end else if (wr_hit(wr_i, ADDR_PD_KEEP) &&
                 pd_state == CCB_ACTIVE) begin
      keep_config_in_powerdown <= wr_i.data[KEEP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stopped state and feedback impedance, byte 11

  // Stopped state, low two bits; both output gates share it
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stopped_output_state <= STOP_RST;
    end else if (restore) begin
      stopped_output_state <= STOP_RST;
    end else if (wr_hit(wr_i, ADDR_STOP_FB)) begin
      stopped_output_state <= wr_i.data[STOP_LSB +: 2];
    end
  end

  // Feedback impedance, upper two bits; the middle bits are dropped
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      feedback_impedance_sel <= FB_Z_RST;
    end else if (restore) begin
      feedback_impedance_sel <= FB_Z_RST;
    end else if (wr_hit(wr_i, ADDR_STOP_FB)) begin
      feedback_impedance_sel <= wr_i.data[FB_Z_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output impedances, bytes 12 and 13

  // Output 0, upper two bits of its byte
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out0_impedance_sel <= OUT0_Z_RST;
    end else if (restore) begin
      out0_impedance_sel <= OUT0_Z_RST;
    end else if (wr_hit(wr_i, ADDR_OUT0_Z)) begin
      out0_impedance_sel <= wr_i.data[OUT0_Z_LSB +: 2];
    end
  end

  // Output 1, lower two bits of its byte
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out1_impedance_sel <= OUT1_Z_RST;
    end else if (restore) begin
      out1_impedance_sel <= OUT1_Z_RST;
    end else if (wr_hit(wr_i, ADDR_OUT1_Z)) begin
      out1_impedance_sel <= wr_i.data[OUT1_Z_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Valid follows the request by exactly one edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
    end
  end

  // One cycle latency; unknown and reserved bytes read zero
  // A write in the same cycle is not seen: the old byte comes back
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= RSVD_READ;
    end else begin
      if (rd_en_i) begin
        unique case (rd_addr_i)
          ADDR_REV_VENDOR: rd_data_o <= {REVISION_CODE, VENDOR_CODE};
          ADDR_PART_CODE: rd_data_o <= {part_class_code, part_number_code};
          ADDR_BLOCK_LEN: rd_data_o <= {3'h0, readback_length};
          ADDR_RSVD_A, ADDR_RSVD_B: rd_data_o <= RSVD_READ;
          ADDR_PD_KEEP: rd_data_o <= {1'b0, keep_config_in_powerdown,
                                      6'h00};
          ADDR_STOP_FB: rd_data_o <= {feedback_impedance_sel, 4'h0,
                                      stopped_output_state};
          ADDR_OUT0_Z: rd_data_o <= {out0_impedance_sel, 6'h00};
          ADDR_OUT1_Z: rd_data_o <= {6'h00, out1_impedance_sel};
          default: rd_data_o <= RSVD_READ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field outputs

  // Straight from the flops so the engine and trim see no glitches
  assign readback_length_o = readback_length;
  assign keep_config_in_powerdown_o = keep_config_in_powerdown;
  assign stopped_output_state_o = stopped_output_state;
  assign feedback_impedance_sel_o = feedback_impedance_sel;
  assign out0_impedance_sel_o = out0_impedance_sel;
  assign out1_impedance_sel_o = out1_impedance_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Output gating

  // Both outputs park in the one programmed stopped state
  ccb_stop_ctrl u_stop0 (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .en_bit_i(out_en_bit_i[0]),
    .pin_en_i(out_pin_en_i[0]),
    .stop_code_i(stopped_output_state),
    .drive_o(out0_drive_o)
  );

  ccb_stop_ctrl u_stop1 (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .en_bit_i(out_en_bit_i[1]),
    .pin_en_i(out_pin_en_i[1]),
    .stop_code_i(stopped_output_state),
    .drive_o(out1_drive_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Impedance decode

  // A reserved code trims nothing and raises its flag instead
  ccb_zout_decode u_zfb (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .code_i(feedback_impedance_sel),
    .ohms_o(feedback_ohms_o),
    .reserved_o(zout_reserved_o[0])
  );

  ccb_zout_decode u_z0 (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .code_i(out0_impedance_sel),
    .ohms_o(out0_ohms_o),
    .reserved_o(zout_reserved_o[1])
  );

  ccb_zout_decode u_z1 (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .code_i(out1_impedance_sel),
    .ohms_o(out1_ohms_o),
    .reserved_o(zout_reserved_o[2])
  );

endmodule

//--- rtl/ccb_pkg.sv
// Behaviour
// - Byte 5 read-only revision and vendor codes
// - Byte 6 writable part class and number
// - Byte 7 low five bits: readback length, eight
// - Bytes 8 and 9 reserved, no effect
// - Byte 10 bit 6 keeps config in powerdown
// - Byte 11 bits 1:0 select stopped output state
// - Byte 11 bits 7:6 select feedback impedance
// - Bytes 12, 13 select output impedances
// - Impedance defaults follow the device variant
// - Cleared enable bit forces programmed stopped state
package ccb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_REV_VENDOR = 8'h05;
  localparam logic [7:0] ADDR_PART_CODE = 8'h06;
  localparam logic [7:0] ADDR_BLOCK_LEN = 8'h07;
  localparam logic [7:0] ADDR_RSVD_A = 8'h08;
  localparam logic [7:0] ADDR_RSVD_B = 8'h09;
  localparam logic [7:0] ADDR_PD_KEEP = 8'h0a;
  localparam logic [7:0] ADDR_STOP_FB = 8'h0b;
  localparam logic [7:0] ADDR_OUT0_Z = 8'h0c;
  localparam logic [7:0] ADDR_OUT1_Z = 8'h0d;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int REV_LSB = 4;
  localparam int CLASS_LSB = 6;
  localparam int KEEP_BIT = 6;
  localparam int FB_Z_LSB = 6;
  localparam int STOP_LSB = 0;
  localparam int OUT0_Z_LSB = 6;
  localparam int OUT1_Z_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [4:0] BLOCK_LEN_RST = 5'h08;
  localparam logic KEEP_RST = 1'b0;
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [7:0] RSVD_READ = 8'h00;

  // Identity codes, values arbitrary
  localparam logic [3:0] REVISION_CODE = 4'h3;
  localparam logic [3:0] VENDOR_CODE = 4'h5;
  localparam logic [1:0] PART_CLASS_RST = 2'h2;
  localparam logic [5:0] PART_NUMBER_RST = 6'h15;

  ////////////////////////////////////////////////////////////////////////////
  // Stopped output state codes
  localparam logic [1:0] STOP_LOW_LOW = 2'h0;
  localparam logic [1:0] STOP_HIZ = 2'h1;
  localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
  localparam logic [1:0] STOP_LOW_HIGH = 2'h3;

  // Impedance codes and their values in ohms
  localparam logic [1:0] ZOUT_33 = 2'h0;
  localparam logic [1:0] ZOUT_85 = 2'h1;
  localparam logic [1:0] ZOUT_100 = 2'h2;
  localparam logic [1:0] ZOUT_RSVD = 2'h3;
  localparam logic [6:0] OHMS_33 = 7'h21;
  localparam logic [6:0] OHMS_85 = 7'h55;
  localparam logic [6:0] OHMS_100 = 7'h64;
  localparam logic [6:0] OHMS_NONE = 7'h00;

  // Device variants
  localparam logic [1:0] VARIANT_100 = 2'h0;
  localparam logic [1:0] VARIANT_85 = 2'h1;
  localparam logic [1:0] VARIANT_FACTORY = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ccb_wr_type;

  typedef struct packed {
    logic running;
    logic true_lvl;
    logic comp_lvl;
    logic hiz;
  } ccb_drive_type;

  typedef enum logic {
    CCB_ACTIVE,
    CCB_POWERED_DOWN
  } ccb_pd_state_type;

  // Power-up impedance per variant
  function automatic logic [1:0] ccb_zout_default(
    input logic [1:0] variant,
    input logic [1:0] factory
  );
    if (variant == VARIANT_100) begin
      return ZOUT_100;
    end else if (variant == VARIANT_85) begin
      return ZOUT_85;
    end else begin
      return factory;
    end
  endfunction

endpackage

//--- rtl/ccb_zout_decode.sv
`timescale 1ns/1ps
// Turns an impedance code into ohms for the analog trim
module ccb_zout_decode
  import ccb_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Code
  input wire logic [1:0] code_i,
  // Result
  output logic [6:0] ohms_o,
  output logic reserved_o
);

  // Registered so the trim sees no decode glitches
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ohms_o <= OHMS_NONE;
      reserved_o <= 1'b0;
    end else begin
      unique case (code_i)
        ZOUT_33: ohms_o <= OHMS_33;
        ZOUT_85: ohms_o <= OHMS_85;
        ZOUT_100: ohms_o <= OHMS_100;
        ZOUT_RSVD: ohms_o <= OHMS_NONE;
      endcase
      reserved_o <= (code_i == ZOUT_RSVD);
    end
  end

endmodule

//--- rtl/ccb_stop_ctrl.sv
`timescale 1ns/1ps
// Per-output gate: runs the clock or parks it in the stopped state
module ccb_stop_ctrl
  import ccb_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Enables
  input wire logic en_bit_i,
  input wire logic pin_en_i,
  // Stopped state code
  input wire logic [1:0] stop_code_i,
  // Drive request
  output ccb_drive_type drive_o
);

  // A cleared enable bit overrides the pin
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_o <= '0;
    end else begin
      drive_o.running <= en_bit_i && pin_en_i;
      unique case (stop_code_i)
        STOP_LOW_LOW: begin
          drive_o.true_lvl <= 1'b0;
          drive_o.comp_lvl <= 1'b0;
          drive_o.hiz <= 1'b0;
        end
        STOP_HIZ: begin
          drive_o.true_lvl <= 1'b0;
          drive_o.comp_lvl <= 1'b0;
          drive_o.hiz <= 1'b1;
        end
        STOP_HIGH_LOW: begin
          drive_o.true_lvl <= 1'b1;
          drive_o.comp_lvl <= 1'b0;
          drive_o.hiz <= 1'b0;
        end
        STOP_LOW_HIGH: begin
          drive_o.true_lvl <= 1'b0;
          drive_o.comp_lvl <= 1'b1;
          drive_o.hiz <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- verif/ccb_cfg_regs_asserts.sv
`timescale 1ns/1ps
// Port-level checks on the config register bank
module ccb_cfg_regs_chk
  import ccb_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Access
  input wire ccb_wr_type wr_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  // Controls and results
  input wire logic pd_i,
  input wire logic [1:0] out_en_bit_i,
  input wire logic [1:0] out_pin_en_i,
  input wire logic [4:0] readback_length_o,
  input wire logic [1:0] stopped_output_state_o,
  input wire logic [1:0] feedback_impedance_sel_o,
  input wire logic [2:0] zout_reserved_o,
  input wire ccb_drive_type out0_drive_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Read answers; writes judged only well clear of power down
  a_read_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered next cycle");
  a_read_quiet: assert property (!rd_en_i |=> !rd_valid_o)
    else $error("read valid without request");
  a_rev_vendor: assert property (
    rd_en_i && rd_addr_i == ADDR_REV_VENDOR
    |=> rd_data_o == {REVISION_CODE, VENDOR_CODE})
    else $error("identity byte wrong");
  a_rsvd_read: assert property (
    rd_en_i && (rd_addr_i == ADDR_RSVD_A || rd_addr_i == ADDR_RSVD_B)
    |=> rd_data_o == RSVD_READ)
    else $error("reserved byte not zero");
  a_length_write: assert property (
    wr_i.en && wr_i.addr == ADDR_BLOCK_LEN && !pd_i && !$past(pd_i)
    |=> readback_length_o == $past(wr_i.data[4:0]))
    else $error("length write lost");
  a_stop_write: assert property (
    wr_i.en && wr_i.addr == ADDR_STOP_FB && !pd_i && !$past(pd_i)
    |=> {feedback_impedance_sel_o, stopped_output_state_o} ==
    {$past(wr_i.data[7:6]), $past(wr_i.data[1:0])})
    else $error("stop byte write lost");
  a_fb_reserved: assert property (
    zout_reserved_o[0] == ($past(feedback_impedance_sel_o) == ZOUT_RSVD))
    else $error("reserved code flag wrong");
  a_stop_hiz: assert property (
    !out_en_bit_i[0] && stopped_output_state_o == STOP_HIZ
    |=> out0_drive_o.hiz && !out0_drive_o.running)
    else $error("stopped output not parked high impedance");
  a_run_gate: assert property (
    out_en_bit_i[0] && out_pin_en_i[0] |=> out0_drive_o.running)
    else $error("enabled output not running");
  // Main scenarios
  cover property (rd_en_i && rd_addr_i == ADDR_REV_VENDOR);
  cover property (pd_i ##1 pd_i ##1 !pd_i);
  cover property (zout_reserved_o[0]);
endmodule
bind ccb_cfg_regs ccb_cfg_regs_chk ccb_cfg_regs_chk_inst (
  .mclk_i, .nrst_i, .wr_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_valid_o,
  .pd_i, .out_en_bit_i, .out_pin_en_i, .readback_length_o,
  .stopped_output_state_o, .feedback_impedance_sel_o, .zout_reserved_o,
  .out0_drive_o
);

//--- verif/ccb_host_model.sv
`timescale 1ns/1ps
// Management-bus host: issues byte writes and byte reads
module ccb_host_model
  import ccb_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Requests
  output ccb_wr_type wr_o,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  // Answers
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  // Quiet bus from time zero
  initial begin
    wr_o = '0;
    rd_en_o = 1'b0;
    rd_addr_o = 8'h00;
  end
  // One write; idle bus shows inverted values so nothing stale passes
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    wr_o = '{en: 1'b1, addr: a, data: d};
    @(negedge mclk_i);
    wr_o = '{en: 1'b0, addr: ~a, data: ~d};
  endtask
  // One read; the answer stands one cycle after the request
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge mclk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
    d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
  endtask
endmodule

//--- verif/test_clock_buffer_cfg_regs_b5_13.sv
`timescale 1ns/1ps
// Self-checking bench for the config register bank
module test_clock_buffer_cfg_regs_b5_13;
  import ccb_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i;
  ccb_wr_type wr_i;
  logic rd_en_i;
  logic [7:0] rd_addr_i;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic pd_i;
  logic keep_config_in_powerdown_o;
  logic [4:0] readback_length_o;
  logic [1:0] out_en_bit_i;
  logic [1:0] out_pin_en_i;
  logic [1:0] stopped_output_state_o;
  ccb_drive_type out0_drive_o;
  ccb_drive_type out1_drive_o;
  logic [1:0] feedback_impedance_sel_o;
  logic [1:0] out0_impedance_sel_o;
  logic [1:0] out1_impedance_sel_o;
  logic [6:0] feedback_ohms_o;
  logic [6:0] out0_ohms_o;
  logic [6:0] out1_ohms_o;
  logic [2:0] zout_reserved_o;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] rd;
  logic [6:0] ohms [3] = '{7'h21, 7'h55, 7'h64};
  logic [3:0] parked [4] = '{4'h0, 4'h1, 4'h4, 4'h2};

  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  ccb_cfg_regs ccb_cfg_regs_inst (
    .mclk_i, .nrst_i, .wr_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_valid_o,
    .readback_length_o, .pd_i, .keep_config_in_powerdown_o, .out_en_bit_i,
    .out_pin_en_i, .stopped_output_state_o, .out0_drive_o, .out1_drive_o,
    .feedback_impedance_sel_o, .out0_impedance_sel_o, .out1_impedance_sel_o,
    .feedback_ohms_o, .out0_ohms_o, .out1_ohms_o, .zout_reserved_o
  );
  ccb_host_model ccb_host_model_inst (
    .mclk_i, .wr_o(wr_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i),
    .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared compare, access and timing helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    ccb_host_model_inst.read_byte(a, rd);
    chk($sformatf("byte %h", a), e, rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ccb_host_model_inst.write_byte(a, d);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic power_cycle;
    pd_i = 1'b1;
    cycles(4);
    pd_i = 1'b0;
    cycles(2);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    pd_i = 1'b0;
    out_en_bit_i = 2'b00;
    out_pin_en_i = 2'b11;
    nrst_i = 1'b0;
    cycles(10);
    nrst_i = 1'b1;
    rd_chk(ADDR_REV_VENDOR, {REVISION_CODE, VENDOR_CODE});
    rd_chk(ADDR_PART_CODE, {PART_CLASS_RST, PART_NUMBER_RST});
    rd_chk(ADDR_BLOCK_LEN, 8'h08);
    rd_chk(ADDR_RSVD_A, 8'h00);
    rd_chk(ADDR_RSVD_B, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(ADDR_PD_KEEP, 8'h00);
    rd_chk(ADDR_STOP_FB, {ZOUT_100, 6'h00});
    rd_chk(ADDR_OUT0_Z, {ZOUT_100, 6'h00});
    rd_chk(ADDR_OUT1_Z, {6'h00, ZOUT_100});
    chk("length", 8'h08, {3'h0, readback_length_o});
    $display("test reset_values done");
    wr(ADDR_REV_VENDOR, 8'hff);
    rd_chk(ADDR_REV_VENDOR, {REVISION_CODE, VENDOR_CODE});
    wr(ADDR_PART_CODE, 8'h4a);
    rd_chk(ADDR_PART_CODE, 8'h4a);
    wr(ADDR_BLOCK_LEN, 8'hff);
    rd_chk(ADDR_BLOCK_LEN, 8'h1f);
    chk("length", 8'h1f, {3'h0, readback_length_o});
    wr(ADDR_RSVD_A, 8'hff);
    wr(ADDR_RSVD_B, 8'hff);
    rd_chk(ADDR_RSVD_A, 8'h00);
    rd_chk(ADDR_RSVD_B, 8'h00);
    wr(ADDR_PD_KEEP, 8'hbf);
    rd_chk(ADDR_PD_KEEP, 8'h00);
    wr(ADDR_STOP_FB, 8'hff);
    wr(ADDR_OUT0_Z, 8'hff);
    wr(ADDR_OUT1_Z, 8'hff);
    rd_chk(ADDR_STOP_FB, 8'hc3);
    rd_chk(ADDR_OUT0_Z, 8'hc0);
    rd_chk(ADDR_OUT1_Z, 8'h03);
    chk("stop state", 8'h03, {6'h00, stopped_output_state_o});
    chk("fb sel", 8'h03, {6'h00, feedback_impedance_sel_o});
    chk("out0 sel", 8'h03, {6'h00, out0_impedance_sel_o});
    chk("out1 sel", 8'h03, {6'h00, out1_impedance_sel_o});
    chk("reserved codes", 8'h07, {5'h00, zout_reserved_o});
    chk("ohms fb", 8'h00, {1'b0, feedback_ohms_o});
    $display("test write_access done");
    // Every legal impedance code on every output
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_STOP_FB, {c[1:0], 6'h00});
      wr(ADDR_OUT0_Z, {c[1:0], 6'h00});
      wr(ADDR_OUT1_Z, {6'h00, c[1:0]});
      cycles(2);
      chk("ohms fb", {1'b0, ohms[c]}, {1'b0, feedback_ohms_o});
      chk("ohms out0", {1'b0, ohms[c]}, {1'b0, out0_ohms_o});
      chk("ohms out1", {1'b0, ohms[c]}, {1'b0, out1_ohms_o});
    end
    $display("test impedance done");
    // Every stopped state while the enable bits are cleared
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_STOP_FB, {6'h00, s[1:0]});
      cycles(2);
      chk("out0 drive", {4'h0, parked[s]}, {4'h0, out0_drive_o});
      chk("out1 drive", {4'h0, parked[s]}, {4'h0, out1_drive_o});
    end
    // Enable bits set: the pins decide, output 0 pin then dropped
    out_en_bit_i = 2'b11;
    cycles(2);
    chk("out0 run", 8'h01, {7'h00, out0_drive_o.running});
    chk("out1 run", 8'h01, {7'h00, out1_drive_o.running});
    out_pin_en_i = 2'b10;
    cycles(2);
    chk("out0 run", 8'h00, {7'h00, out0_drive_o.running});
    chk("out1 run", 8'h01, {7'h00, out1_drive_o.running});
    $display("test stop_state done");
    wr(ADDR_BLOCK_LEN, 8'h05);
    power_cycle();
    rd_chk(ADDR_BLOCK_LEN, 8'h08);
    rd_chk(ADDR_PART_CODE, {PART_CLASS_RST, PART_NUMBER_RST});
    rd_chk(ADDR_STOP_FB, {ZOUT_100, 6'h00});
    wr(ADDR_PD_KEEP, 8'h40);
    rd_chk(ADDR_PD_KEEP, 8'h40);
    wr(ADDR_BLOCK_LEN, 8'h05);
    power_cycle();
    rd_chk(ADDR_BLOCK_LEN, 8'h05);
    chk("keep", 8'h01, {7'h00, keep_config_in_powerdown_o});
    $display("test power_down done");
    // Mid-run reset brings the fields back to their power-up values
    nrst_i = 1'b0;
    cycles(2);
    nrst_i = 1'b1;
    rd_chk(ADDR_BLOCK_LEN, 8'h08);
    chk("keep", 8'h00, {7'h00, keep_config_in_powerdown_o});
    $display("test reset_again done");
    stop_test();
  end

  // Watchdog, far beyond the roughly 140 cycles the tests need
  initial begin
    #200_000;
    fail_count++;
    stop_test();
  end
endmodule
